// [bench/sli_top_properties.sv]
/*
  Port-level checker for sli_top: bus wait states, read-clear and irq gating.
  Assumes it is bound into sli_top with one clock and active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sli_top_properties
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Events
  input wire logic crc_frame_done,
  input wire logic crc_frame_bad,
  input wire logic rx_byte_valid,
  input wire logic rx_msg_end,
  input wire logic tx_start_event,
  input wire logic rx_start_event,
  input wire logic tx_end_event,
  input wire logic rx_end_event,
  // Interrupt
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic acc = (avs_read || avs_write) && !avs_waitrequest;
  wire logic rd0 = avs_read && avs_address == sli_pkg::SLI_OFF_STATUS;
  wire logic [3:0] evt = {tx_start_event, rx_start_event, tx_end_event, rx_end_event};
  wire logic en_wr = acc && avs_write && avs_byteenable[0]
    && avs_address == sli_pkg::SLI_OFF_ENABLE;
  logic [7:0] en_reg;
  // Shadow of the enable register, only the bus can change it
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) en_reg <= 8'h00;
    else if (en_wr) en_reg <= avs_writedata[7:0];
  AST_FIRST_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state");
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state too long");
  AST_HI_ZERO: assert property (acc && avs_read |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_MASKED: assert property (en_reg[5:0] == 6'h00 |-> !irq)
    else $error("irq while all masked");
  AST_EVT_IRQ: assert property ((evt & en_reg[5:2]) != 4'h0 |=> irq)
    else $error("enabled event gave no irq");
  AST_RD_SET: assert property (tx_start_event ##[1:3] (rd0 && avs_waitrequest)
    |=> avs_readdata[5])
    else $error("event not reported");
  AST_RD_CLEAR: assert property ($past(evt) == 4'h0 && evt == 4'h0 && acc && rd0 ##1
    evt == 4'h0 ##1 (rd0 && avs_waitrequest) |=> avs_readdata[5:2] == 4'h0)
    else $error("flags survived read");
  AST_IRQ_HOLD: assert property (irq && !acc |=> irq)
    else $error("irq dropped without access");
  cover property (acc && rd0);
  cover property ($rose(irq));
  cover property (en_wr);
endmodule : sli_top_properties
bind sli_top sli_top_properties chk_u (.*);
`default_nettype wire

// [bench/test_sli_top.sv]
/*
  Self-checking bench for sli_top: table of event cases, then link failure,
  long message and reset cases.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module test_sli_top;
  localparam logic [3:0] ST = sli_pkg::SLI_OFF_STATUS;
  localparam logic [3:0] EN = sli_pkg::SLI_OFF_ENABLE;
  logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic crc_frame_done = 1'b0, crc_frame_bad = 1'b0, rx_byte_valid = 1'b0, rx_msg_end = 1'b0;
  logic tx_start_event = 1'b0, rx_start_event = 1'b0, tx_end_event = 1'b0, rx_end_event = 1'b0;
  logic avs_waitrequest, irq;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  // Row: events {tx start, rx start, tx end, rx end}, enable, irq
  logic [10:0] rows [7] = '{11'b1000_100000_1, 11'b0100_010000_1, 11'b0010_001000_1,
    11'b0001_000100_1, 11'b1000_011111_0, 11'b0101_101011_0, 11'b1111_111100_1};
  sli_top dut_u (.*);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    logic ws;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(negedge clk);
      ws = avs_waitrequest;
      @(posedge clk);
    end
    while (ws);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic st(input logic [7:0] e);
    acc(1'b0, ST, 8'h00);
    `CHK(q[7:0], e)
  endtask : st
  // Frames or bytes held for n cycles: 0 bad, 1 byte, 2 good, 3 last byte
  task automatic run(input logic [1:0] k, input int n);
    crc_frame_done <= !k[0];
    crc_frame_bad <= k == 2'h0;
    rx_byte_valid <= k[0];
    rx_msg_end <= k == 2'h3;
    repeat (n) @(posedge clk);
    {crc_frame_done, crc_frame_bad, rx_byte_valid, rx_msg_end} <= 4'h0;
    repeat (2) @(posedge clk);
  endtask : run
  task automatic ev(input logic [3:0] e);
    {tx_start_event, rx_start_event, tx_end_event, rx_end_event} <= e;
    @(posedge clk);
    {tx_start_event, rx_start_event, tx_end_event, rx_end_event} <= 4'h0;
    @(posedge clk);
  endtask : ev
  task automatic ck_irq(input logic e);
    @(negedge clk);
    `CHK(irq, e)
    @(posedge clk);
  endtask : ck_irq
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      acc(1'b1, EN, {2'h0, rows[i][6:1]});
      ev(rows[i][10:7]);
      ck_irq(rows[i][0]);
      st({2'h0, rows[i][10:7], 2'h0});
      st(8'h00);
      ck_irq(1'b0);
    end
    $display("table done");
    acc(1'b1, EN, 8'h02);
    run(2'h0, 31);
    ck_irq(1'b0);
    run(2'h0, 1);
    ck_irq(1'b1);
    st(8'h02);
    run(2'h0, 9);
    st(8'h00);
    run(2'h2, 1);
    run(2'h0, 31);
    st(8'h00);
    run(2'h0, 1);
    st(8'h02);
    acc(1'b1, sli_pkg::SLI_OFF_CTRL, 8'h01);
    run(2'h2, 1);
    run(2'h0, 63);
    st(8'h00);
    run(2'h0, 1);
    st(8'h02);
    $display("link failure done");
    acc(1'b1, EN, 8'h01);
    run(2'h1, 276);
    st(8'h00);
    run(2'h1, 1);
    ck_irq(1'b1);
    st(8'h01);
    run(2'h3, 1);
    run(2'h1, 277);
    st(8'h01);
    $display("long message done");
    // Event lands on the clearing edge of a read: set must win
    ev(4'h8);
    fork
      acc(1'b0, ST, 8'h00);
      begin
        @(posedge clk);
        tx_start_event <= 1'b1;
        @(posedge clk);
        tx_start_event <= 1'b0;
      end
    join
    `CHK(q[7:0], 8'h20)
    st(8'h20);
    // Write one to clear, lane 0 masked write, control readback
    ev(4'hF);
    acc(1'b1, ST, 8'h28);
    st(8'h14);
    avs_byteenable <= 4'hE;
    acc(1'b1, EN, 8'h3F);
    avs_byteenable <= 4'hF;
    acc(1'b0, EN, 8'h00);
    `CHK(q[7:0], 8'h01)
    acc(1'b0, sli_pkg::SLI_OFF_CTRL, 8'h00);
    `CHK(q[7:0], 8'h01)
    $display("clear cases done");
    ev(4'hF);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    ck_irq(1'b0);
    st(8'h00);
    acc(1'b0, EN, 8'h00);
    `CHK(q[7:0], 8'h00)
    acc(1'b0, sli_pkg::SLI_OFF_CTRL, 8'h00);
    `CHK(q[7:0], 8'h00)
    $display("reset done");
    test_done();
  end
endmodule : test_sli_top
`default_nettype wire

// [src/sli_crc_fail_det.sv]
/*
  Counts consecutive signalling frames with corrupted CRC and pulses once when
  the run reaches the selected threshold.
  Assumes frame_done is a one-cycle pulse per frame with frame_bad valid beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_crc_fail_det
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Frame results
  input wire logic frame_done,
  input wire logic frame_bad,
  // Events
  sli_evt_if.crc_side evt
);

  logic [6:0] count_reg;
  logic [6:0] count_next;
  logic fail_reg;
  logic fail_next;
  logic [6:0] threshold;
  logic below;
  logic [6:0] count_inc;

  assign threshold = evt.thresh_sel ? sli_pkg::SLI_CRC_THRESH_HIGH
                                    : sli_pkg::SLI_CRC_THRESH_LOW;
  assign below = count_reg < threshold;
  assign count_inc = count_reg + 7'h01;

  // Counter saturates at the threshold so one run fires only once
  assign count_next = !frame_done ? count_reg :
                      !frame_bad ? 7'h00 :
                      below ? count_inc : count_reg;
  assign fail_next = frame_done && frame_bad && below && (count_inc == threshold);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_reg <= 7'h00;
      fail_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      fail_reg <= fail_next;
    end
  end

  assign evt.link_fail_pulse = fail_reg;

endmodule : sli_crc_fail_det

`default_nettype wire

// [src/sli_evt_if.sv]
/*
  Interface carrying detector events and the threshold select between the
  detectors and the register block.
  Assumes all parties share one clock; events are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none

interface sli_evt_if;
  logic link_fail_pulse;
  logic long_msg_pulse;
  logic thresh_sel;

  modport crc_side (output link_fail_pulse, input thresh_sel);
  modport len_side (output long_msg_pulse);
  modport reg_side (input link_fail_pulse, input long_msg_pulse, output thresh_sel);
endinterface : sli_evt_if

`default_nettype wire

// [src/sli_msg_len_det.sv]
/*
  Counts bytes of the received message and pulses once when it grows past the
  longest legal length.
  Assumes byte_valid per received byte and msg_end on the last byte of a message.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_msg_len_det
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Receive byte stream
  input wire logic byte_valid,
  input wire logic msg_end,
  // Events
  sli_evt_if.len_side evt
);

  logic [8:0] len_reg;
  logic [8:0] len_next;
  logic long_reg;
  logic long_next;
  logic at_limit;
  logic past_limit;

  assign at_limit = len_reg == sli_pkg::SLI_MAX_MSG_BYTES;
  assign past_limit = len_reg > sli_pkg::SLI_MAX_MSG_BYTES;

  // Count stops one past the limit; a byte on msg_end still belongs to the message
  assign len_next = msg_end ? 9'h000 :
                    (byte_valid && !past_limit) ? len_reg + 9'h001 : len_reg;
  assign long_next = byte_valid && at_limit;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      len_reg <= 9'h000;
      long_reg <= 1'b0;
    end
    else
    begin
      len_reg <= len_next;
      long_reg <= long_next;
    end
  end

  assign evt.long_msg_pulse = long_reg;

endmodule : sli_msg_len_det

`default_nettype wire

// [src/sli_pkg.sv]
/*
  Package for the signalling-link interrupt block: register offsets, field positions,
  reset values and detector limits.
  Assumes a 32-bit Avalon-MM slave port with byte addresses and one register per word.
*/
package sli_pkg;

  // Byte offsets on the register port
  localparam logic [3:0] SLI_OFF_STATUS = 4'h0;
  localparam logic [3:0] SLI_OFF_ENABLE = 4'h4;
  localparam logic [3:0] SLI_OFF_CTRL = 4'h8;

  // Register widths and reset values
  localparam int SLI_REG_W = 8;
  localparam int SLI_FLAG_W = 6;
  localparam logic [7:0] SLI_STATUS_RST = 8'h00;
  localparam logic [7:0] SLI_ENABLE_RST = 8'h00;
  localparam logic [7:0] SLI_CTRL_RST = 8'h00;

  // Field positions shared by status and enable
  localparam int SLI_BIT_LONG_MSG = 0;
  localparam int SLI_BIT_LINK_FAIL = 1;
  localparam int SLI_BIT_RX_END = 2;
  localparam int SLI_BIT_TX_END = 3;
  localparam int SLI_BIT_RX_START = 4;
  localparam int SLI_BIT_TX_START = 5;

  // Control register: threshold select
  localparam int SLI_BIT_THRESH_SEL = 0;

  // CRC failure detector
  localparam int SLI_CRC_CNT_W = 7;
  localparam logic [6:0] SLI_CRC_THRESH_LOW = 7'h20;
  localparam logic [6:0] SLI_CRC_THRESH_HIGH = 7'h40;

  // Message length detector
  localparam int SLI_LEN_W = 9;
  localparam logic [8:0] SLI_MAX_MSG_BYTES = 9'h114;

endpackage : sli_pkg

// [src/sli_top.sv]
/*
  Signalling-link interrupt block: status, enable and control registers on an
  Avalon-MM slave, the two detectors and the interrupt output.
  Assumes all event inputs are synchronous one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Receive CRC frame results
  input wire logic crc_frame_done,
  input wire logic crc_frame_bad,
  // Receive message bytes
  input wire logic rx_byte_valid,
  input wire logic rx_msg_end,
  // Signalling unit events
  input wire logic tx_start_event,
  input wire logic rx_start_event,
  input wire logic tx_end_event,
  input wire logic rx_end_event,
  // Interrupt
  output logic irq
);

  typedef enum logic {BUS_IDLE, BUS_DONE} sli_bus_phase_type;

  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] offset);
    addr_hit = addr == offset;
  endfunction : addr_hit

  // Set wins over clear so an event in the clearing cycle survives
  function automatic logic [5:0] sticky_update(input logic [5:0] cur, input logic [5:0] set,
                                                input logic [5:0] clr);
    sticky_update = (cur & ~clr) | set;
  endfunction : sticky_update

  sli_evt_if evt_bus ();

  sli_crc_fail_det u_crc_fail_det
  (
    .clk(clk),
    .rst_b(rst_b),
    .frame_done(crc_frame_done),
    .frame_bad(crc_frame_bad),
    .evt(evt_bus.crc_side)
  );

  sli_msg_len_det u_msg_len_det
  (
    .clk(clk),
    .rst_b(rst_b),
    .byte_valid(rx_byte_valid),
    .msg_end(rx_msg_end),
    .evt(evt_bus.len_side)
  );

  // Register state
  sli_bus_phase_type phase_reg;
  sli_bus_phase_type phase_next;
  logic [5:0] status_reg;
  logic [5:0] status_next;
  logic [5:0] enable_reg;
  logic [5:0] enable_next;
  logic ctrl_thresh_reg;
  logic ctrl_thresh_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic [5:0] snap_reg;
  logic [5:0] snap_next;

  // Bus decode
  wire req = avs_read || avs_write;
  wire accept = req && (phase_reg == BUS_DONE);
  wire capture = req && (phase_reg == BUS_IDLE);
  wire hit_status = addr_hit(avs_address, sli_pkg::SLI_OFF_STATUS);
  wire hit_enable = addr_hit(avs_address, sli_pkg::SLI_OFF_ENABLE);
  wire hit_ctrl = addr_hit(avs_address, sli_pkg::SLI_OFF_CTRL);
  wire lane0_write = accept && avs_write && avs_byteenable[0];

  // One wait state: data is registered before waitrequest drops
  assign avs_waitrequest = capture;
  assign phase_next = capture ? BUS_DONE : BUS_IDLE;

  // Read mux; reserved bits 7:6 and upper lanes read zero
  wire [7:0] status_view = {2'b00, status_reg};
  wire [7:0] enable_view = {2'b00, enable_reg};
  wire [7:0] ctrl_view = {7'h00, ctrl_thresh_reg};
  wire [7:0] read_mux = hit_status ? status_view :
                        hit_enable ? enable_view :
                        hit_ctrl ? ctrl_view : 8'h00;
  assign readdata_next = capture ? {24'h000000, read_mux} : readdata_reg;

  // Snapshot of the flags actually returned; only those get cleared
  assign snap_next = (capture && avs_read && hit_status) ? status_reg : snap_reg;

  // Event vector in status bit order
  wire [5:0] set_vec = {tx_start_event, rx_start_event, tx_end_event, rx_end_event,
                        evt_bus.link_fail_pulse, evt_bus.long_msg_pulse};

  // Clear on read of status, or write one to clear
  wire [5:0] read_clear = (accept && avs_read && hit_status) ? snap_reg : 6'h00;
  wire [5:0] write_clear = (lane0_write && hit_status) ? avs_writedata[5:0] : 6'h00;
  assign status_next = sticky_update(status_reg, set_vec, read_clear | write_clear);

  assign enable_next = (lane0_write && hit_enable) ? avs_writedata[5:0] : enable_reg;
  assign ctrl_thresh_next = (lane0_write && hit_ctrl) ?
                            avs_writedata[sli_pkg::SLI_BIT_THRESH_SEL] : ctrl_thresh_reg;

  assign evt_bus.thresh_sel = ctrl_thresh_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      phase_reg <= BUS_IDLE;
    else
      phase_reg <= phase_next;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_reg <= sli_pkg::SLI_STATUS_RST[5:0];
      snap_reg <= 6'h00;
    end
    else
    begin
      status_reg <= status_next;
      snap_reg <= snap_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enable_reg <= sli_pkg::SLI_ENABLE_RST[5:0];
      ctrl_thresh_reg <= sli_pkg::SLI_CTRL_RST[0];
    end
    else
    begin
      enable_reg <= enable_next;
      ctrl_thresh_reg <= ctrl_thresh_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      readdata_reg <= 32'h00000000;
    else
      readdata_reg <= readdata_next;
  end

  assign avs_readdata = readdata_reg;

  // Level interrupt straight from registered flags and enables
  assign irq = |(status_reg & enable_reg);

endmodule : sli_top

`default_nettype wire
